// File: resolver_position_register_interface_tb.sv
// resolver_position_register_interface_tb: APB host end driving the module end
// assumes zero-wait APB slave and a host that reports done in its status
`timescale 1ns/1ns
module resolver_position_register_interface_tb;
  import rpr_pkg::*;
  logic        clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, present, conv, strobe = 1'b0, local_rack = 1'b1;
  logic [15:0] pos = 16'h0000;
  int          n_errors = 0, comparisons = 0, present_cycles = 0;
  always #5 clock = ~clock;
  // cycles since the common clock indicator last came on
  always @(posedge clock) present_cycles <= (present === 1'b1) ? present_cycles + 1 : 0;
  rpr_bp_if bp (.CLOCK(clock));
  rpr_host i_rpr_host (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BP(bp.host));
  rpr_device i_rpr_device (.CLOCK(clock), .SYS_RST(sys_rst), .BP(bp.device),
    .RESOLVER_POS(pos), .STROBE_IN(strobe), .LOCAL_RACK(local_rack),
    .SHARED_CLOCK_PRESENT_INDICATOR(present), .CONVERT_PULSE(conv));
  rpr_bp_props i_rpr_bp_props (.CLOCK(clock), .SYS_RST(sys_rst), .addr(bp.addr),
    .req(bp.req), .wr(bp.wr), .wdata(bp.wdata), .ack(bp.ack), .berr(bp.berr),
    .irq(bp.irq), .cclk_o(bp.cclk_o), .cclk_oe(bp.cclk_oe), .cclk_in(bp.cclk_in));
  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      tally_and_finish();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one backplane transfer through the host command port
  task automatic bp_op(input logic w, input logic [2:0] idx, input logic [15:0] d,
                       output logic e);
    int n;
    apb(1'b1, APB_WDATA, {16'h0, d});
    apb(1'b1, APB_CMD, {28'h0, w, idx});
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (rd[1:0] !== 2'b10 && n < 20);
    if (n >= 20) begin
      n_errors++;
      tally_and_finish();
    end
    e = rd[2];
    apb(1'b0, APB_RDATA, 32'h0);
  endtask : bp_op
  task automatic rd_chk(input logic [2:0] idx, input logic [15:0] exp);
    logic e;
    bp_op(1'b0, idx, 16'h0, e);
    check({e, rd[15:0]}, {1'b0, exp});
  endtask : rd_chk
  task automatic wr_chk(input logic [2:0] idx, input logic [15:0] d, input logic exp_e);
    logic e;
    bp_op(1'b1, idx, d, e);
    check(e, exp_e);
  endtask : wr_chk
  task automatic pulse(input logic [15:0] p);
    pos <= p;
    repeat (4) @(posedge clock);
    strobe <= 1'b1;
    repeat (8) @(posedge clock);
    strobe <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : pulse
  initial begin
    int n;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check(present, 1'b0);
    rd_chk(IDX_STATUS, 16'h0004);
    rd_chk(IDX_CONTROL, CONTROL_RESET);
    rd_chk(IDX_PERIOD, PERIOD_RESET);
    for (int i = 0; i < 3; i++) wr_chk(3'(i), 16'hFFFF, 1'b1);
    rd_chk(IDX_POS_STROBE, 16'h0000);
    pulse(16'h1234);
    rd_chk(IDX_POS_STROBE, 16'h1234);
    pulse(16'h5678);
    rd_chk(IDX_POS_STROBE, 16'h1234);
    wr_chk(IDX_CONTROL, 16'h1041, 1'b0);
    rd_chk(IDX_CONTROL, 16'h0041);
    pulse(16'h5678);
    rd_chk(IDX_POS_STROBE, 16'h5678);
    repeat (CCLK_LOSS_CYC + 4 * CCLK_DIV) @(posedge clock);
    check(present, 1'b1);
    wr_chk(IDX_CONTROL, 16'h0001, 1'b0);
    repeat (CCLK_LOSS_CYC + 20) @(posedge clock);
    check(present, 1'b0);
    rd_chk(IDX_STATUS, 16'h0002);
    pos <= 16'h9ABC;
    wr_chk(IDX_PERIOD, 16'h0001, 1'b0);
    rd_chk(IDX_POS_LIVE, 16'h0000);
    wr_chk(IDX_CONTROL, 16'h0041, 1'b0);
    n = 0;
    while (conv !== 1'b1 && n < UNIT_CYCLES + 100) begin
      @(posedge clock);
      n++;
    end
    check(present_cycles, UNIT_CYCLES);
    rd_chk(IDX_POS_LIVE, 16'h9ABC);
    apb(1'b0, APB_IRQCNT, 32'h0);
    check(rd, 32'h1);
    tally_and_finish();
  end
endmodule : resolver_position_register_interface_tb

// File: rpr_bp_if.sv
// rpr_bp_if: rack backplane between processor end and resolver module
// assumes testbench drives CLOCK; common clock resolved here from the device enable
`timescale 1ns/1ns
interface rpr_bp_if (input wire logic CLOCK);
  import rpr_pkg::*;
  logic [REG_AW-1:0] addr;
  logic              req;
  logic              wr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              ack;
  logic              berr;
  logic              irq;
  logic              cclk_o;
  logic              cclk_oe;
  logic              cclk_in;
  assign cclk_in = cclk_oe & cclk_o;
  modport device (input addr, req, wr, wdata, cclk_in,
                  output rdata, ack, berr, irq, cclk_o, cclk_oe);
  modport host (output addr, req, wr, wdata,
                input rdata, ack, berr, irq);
endinterface : rpr_bp_if

// File: rpr_bp_props.sv
// rpr_bp_props: backplane checker for the resolver register link
// assumes plain backplane signals, one clock, synchronous reset
`timescale 1ns/1ns
module rpr_bp_props
  import rpr_pkg::*;
(
  input wire logic              CLOCK,
  input wire logic              SYS_RST,
  input wire logic [REG_AW-1:0] addr,
  input wire logic              req,
  input wire logic              wr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              ack,
  input wire logic              berr,
  input wire logic              irq,
  input wire logic              cclk_o,
  input wire logic              cclk_oe,
  input wire logic              cclk_in
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic [15:0] gap_q;
  logic [7:0]  div_q;
  logic        in_q;
  logic        o_q;
  // cycles since the common clock last moved
  always_ff @(posedge CLOCK) begin
    in_q  <= cclk_in;
    gap_q <= (SYS_RST || in_q != cclk_in) ? 16'h0000 : gap_q + 16'h0001;
  end
  // cycles since the driven clock last toggled
  always_ff @(posedge CLOCK) begin
    o_q   <= cclk_o;
    div_q <= (SYS_RST || !cclk_oe || o_q != cclk_o) ? 8'h00 : div_q + 8'h01;
  end
  sequence ctl_wr_s(v);
    $rose(req) && wr && addr == IDX_CONTROL && wdata[CTL_CLK_SRC_BIT] == v ##1 ack;
  endsequence
  AST_ANSWER_NEXT: assert property ($rose(req) |=> ack ^ berr)
    else $error("request not answered in one cycle");
  AST_RO_BERR: assert property ($rose(req) && wr && addr <= IDX_STATUS |=> berr)
    else $error("write to read-only register not refused");
  AST_RO_NO_ACK: assert property ($rose(req) && wr && addr <= IDX_STATUS |=> !ack)
    else $error("write to read-only register acknowledged");
  AST_RD_OK: assert property ($rose(req) && !wr && addr <= IDX_PERIOD |=> ack)
    else $error("register read refused");
  AST_PERIOD_WR: assert property ($rose(req) && wr && addr == IDX_PERIOD |=> ack)
    else $error("period write refused");
  AST_CLK_SRC_ON: assert property (ctl_wr_s(1'b1) |-> ##[0:2] cclk_oe)
    else $error("clock source bit did not enable drive");
  AST_CLK_SRC_OFF: assert property (ctl_wr_s(1'b0) |-> ##[0:2] !cclk_oe)
    else $error("clock drive kept after bit cleared");
  AST_CLK_DIV: assert property (cclk_oe |-> div_q <= 8'(CCLK_DIV - 1))
    else $error("driven common clock stalled");
  AST_IRQ_NEEDS_CLK: assert property (irq |-> gap_q < 16'(CCLK_LOSS_CYC + 8))
    else $error("interrupt without common clock");
  AST_IRQ_PULSE: assert property (irq |=> !irq)
    else $error("interrupt longer than one cycle");
endmodule : rpr_bp_props

// File: rpr_device.sv
// rpr_device: resolver module register side on the backplane
// assumes position word comes from converter logic on CLOCK;
// strobe and common clock are asynchronous and synchronised here
// Functional notes
// - registers 0 to 2 refuse host writes
// - position register write returns bus error
// - host uses interrupts only in local rack
// - period register sets conversion rate
// - one period unit is 500 microseconds
// - no conversions without backplane common clock
// - control bit 6 drives common clock out
// - indicator lit while common clock present
// - register 0 refreshed with latest position
// - strobe captures position into register 1
// - strobe ignored until control bit 12 rearms
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ns
module rpr_device
  import rpr_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              SYS_RST,
  rpr_bp_if.device               BP,
  input  wire logic [DATA_W-1:0] RESOLVER_POS,
  input  wire logic              STROBE_IN,
  input  wire logic              LOCAL_RACK,
  output logic                   SHARED_CLOCK_PRESENT_INDICATOR,
  output logic                   CONVERT_PULSE
);
  logic [DATA_W-1:0]      pos_live_q;
  logic [DATA_W-1:0]      pos_strobe_q;
  logic [DATA_W-1:0]      control_q;
  logic [DATA_W-1:0]      period_q;
  logic [DATA_W-1:0]      rdata_q;
  logic                   ack_q;
  logic                   berr_q;
  logic                   irq_q;
  logic                   armed_q;
  logic                   captured_q;
  logic [1:0]             strobe_sync_q;
  logic [1:0]             cclk_sync_q;
  logic [1:0]             rack_sync_q;
  logic                   strobe_prev_q;
  logic                   cclk_prev_q;
  logic                   present_q;
  logic [CCLK_LOSS_W-1:0] loss_cnt_q;
  logic [15:0]            unit_cnt_q;
  logic [15:0]            period_cnt_q;
  logic [7:0]             div_cnt_q;
  logic                   cclk_gen_q;
  logic                   unit_tick;
  logic                   conv;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   ro_hit;

  // register index decode shared by answer and refusal logic
  function automatic logic idx_mapped(input logic [REG_AW-1:0] idx);
    return idx <= IDX_PERIOD;
  endfunction : idx_mapped

  function automatic logic idx_read_only(input logic [REG_AW-1:0] idx);
    return idx <= IDX_STATUS;
  endfunction : idx_read_only

  assign wr_acc = BP.req & BP.wr & ~ack_q & ~berr_q;
  assign rd_acc = BP.req & ~BP.wr & ~ack_q & ~berr_q;
  assign ro_hit = idx_read_only(BP.addr);
  assign BP.ack = ack_q;
  assign BP.berr = berr_q;
  assign BP.rdata = rdata_q;
  assign BP.irq = irq_q;
  assign BP.cclk_o = cclk_gen_q;
  assign BP.cclk_oe = control_q[CTL_CLK_SRC_BIT];
  assign SHARED_CLOCK_PRESENT_INDICATOR = present_q;

  // bus answer one cycle after request; writes low three refused
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ack_q  <= 1'b0;
      berr_q <= 1'b0;
    end else begin
      ack_q  <= (rd_acc | (wr_acc & ~ro_hit)) & idx_mapped(BP.addr);
      berr_q <= (wr_acc & ro_hit) | ((wr_acc | rd_acc) & ~idx_mapped(BP.addr));
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_q <= 16'h0000;
    end else if (rd_acc) begin
      case (BP.addr)
        IDX_POS_LIVE:   rdata_q <= pos_live_q;
        IDX_POS_STROBE: rdata_q <= pos_strobe_q;
        IDX_STATUS:     rdata_q <= {13'h0000, armed_q, captured_q, present_q};
        IDX_CONTROL:    rdata_q <= control_q;
        IDX_PERIOD:     rdata_q <= period_q;
        default:        rdata_q <= 16'h0000;
      endcase
    end
  end

  // control and period registers; rearm bit is write-only pulse
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      control_q <= CONTROL_RESET;
      period_q  <= PERIOD_RESET;
    end else if (wr_acc) begin
      if (BP.addr == IDX_CONTROL) control_q <= BP.wdata & ~(16'h0001 << CTL_REARM_BIT);
      if (BP.addr == IDX_PERIOD) period_q <= BP.wdata;
    end
  end

  // common clock generator when this module is the source
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      div_cnt_q  <= 8'h00;
      cclk_gen_q <= 1'b0;
    end else if (div_cnt_q == 8'(CCLK_DIV - 1)) begin
      div_cnt_q  <= 8'h00;
      cclk_gen_q <= ~cclk_gen_q;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // common clock presence: edges seen within loss window
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      cclk_sync_q <= 2'b00;
      cclk_prev_q <= 1'b0;
      loss_cnt_q  <= '0;
      present_q   <= 1'b0;
    end else begin
      cclk_sync_q <= {cclk_sync_q[0], BP.cclk_in};
      cclk_prev_q <= cclk_sync_q[1];
      if (cclk_sync_q[1] != cclk_prev_q) begin
        loss_cnt_q <= '0;
        present_q  <= 1'b1;
      end else if (loss_cnt_q == CCLK_LOSS_W'(CCLK_LOSS_CYC - 1)) begin
        present_q <= 1'b0;
      end else begin
        loss_cnt_q <= loss_cnt_q + 1'b1;
      end
    end
  end

  // 500 us unit divider, held at zero while clock absent
  assign unit_tick = present_q && unit_cnt_q == 16'(UNIT_CYCLES - 1);
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !present_q) begin
      unit_cnt_q <= 16'h0000;
    end else if (unit_tick) begin
      unit_cnt_q <= 16'h0000;
    end else begin
      unit_cnt_q <= unit_cnt_q + 16'h0001;
    end
  end

  assign conv = unit_tick && period_q != 16'h0000 && period_cnt_q >= period_q - 16'h0001;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      period_cnt_q <= 16'h0000;
    end else if (conv) begin
      period_cnt_q <= 16'h0000;
    end else if (unit_tick) begin
      period_cnt_q <= period_cnt_q + 16'h0001;
    end
  end

  // rack strap pin synchronised before it gates interrupts
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rack_sync_q <= 2'h0;
    end else begin
      rack_sync_q <= {rack_sync_q[0], LOCAL_RACK};
    end
  end

  // conversion updates live position and interrupt
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pos_live_q    <= 16'h0000;
      irq_q         <= 1'b0;
      CONVERT_PULSE <= 1'b0;
    end else begin
      CONVERT_PULSE <= conv;
      if (conv) pos_live_q <= RESOLVER_POS;
      irq_q <= conv & control_q[CTL_IRQ_EN_BIT] & rack_sync_q[1];
    end
  end

  // strobe capture with rearm; rearm write loses to same-cycle strobe
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      strobe_sync_q <= 2'b00;
      strobe_prev_q <= 1'b0;
      pos_strobe_q  <= 16'h0000;
      armed_q       <= 1'b1;
      captured_q    <= 1'b0;
    end else begin
      strobe_sync_q <= {strobe_sync_q[0], STROBE_IN};
      strobe_prev_q <= strobe_sync_q[1];
      if (armed_q && strobe_sync_q[1] && !strobe_prev_q) begin
        pos_strobe_q <= RESOLVER_POS;
        armed_q      <= 1'b0;
        captured_q   <= 1'b1;
      end else if (wr_acc && BP.addr == IDX_CONTROL && BP.wdata[CTL_REARM_BIT]) begin
        armed_q    <= 1'b1;
        captured_q <= 1'b0;
      end
    end
  end
endmodule : rpr_device

// File: rpr_host.sv
// rpr_host: processor end, APB slave command port to backplane master
// assumes an APB master on CLOCK and the device on the backplane
`timescale 1ns/1ns
module rpr_host
  import rpr_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  rpr_bp_if.host           BP
);
  typedef enum {S_IDLE, S_BUSY} rpr_state_e;
  rpr_state_e        state_q;
  logic [REG_AW-1:0] addr_q;
  logic              wr_q, berr_seen_q, done_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic [15:0]       irq_cnt_q;
  logic              acc, wr_ok;

  assign acc   = PSEL & PENABLE;
  assign wr_ok = acc & PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  assign BP.req   = state_q == S_BUSY;
  assign BP.addr  = addr_q;
  assign BP.wr    = wr_q;
  assign BP.wdata = wdata_q;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        APB_RDATA:  PRDATA <= {16'h0000, rdata_q};
        APB_STATUS: PRDATA <= {29'h0, berr_seen_q, done_q, state_q == S_BUSY};
        APB_IRQCNT: PRDATA <= {16'h0000, irq_cnt_q};
        APB_WDATA:  PRDATA <= {16'h0000, wdata_q};
        default:    PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // command: bit 3 write, bits 2:0 register index; issue when idle
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_q     <= S_IDLE;
      addr_q      <= '0;
      wr_q        <= 1'b0;
      wdata_q     <= 16'h0000;
      rdata_q     <= 16'h0000;
      berr_seen_q <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      if (wr_ok && PADDR == APB_WDATA) wdata_q <= PWDATA[15:0];
      case (state_q)
        S_IDLE: begin
          if (wr_ok && PADDR == APB_CMD) begin
            addr_q      <= PWDATA[2:0];
            wr_q        <= PWDATA[3];
            done_q      <= 1'b0;
            berr_seen_q <= 1'b0;
            state_q     <= S_BUSY;
          end
        end
        S_BUSY: begin
          if (BP.ack || BP.berr) begin
            if (BP.ack && !wr_q) rdata_q <= BP.rdata;
            berr_seen_q <= BP.berr;
            done_q      <= 1'b1;
            state_q     <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // interrupts counted only; valid only in a local rack
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      irq_cnt_q <= 16'h0000;
    end else if (BP.irq) begin
      irq_cnt_q <= irq_cnt_q + 16'h0001;
    end
  end
endmodule : rpr_host

// File: rpr_pkg.sv
// rpr_pkg: shared constants for the resolver position register link
// assumes both ends compile against the same package
package rpr_pkg;
  localparam int          REG_AW         = 3;
  localparam int          DATA_W         = 16;
  localparam logic [2:0]  IDX_POS_LIVE   = 3'h0;
  localparam logic [2:0]  IDX_POS_STROBE = 3'h1;
  localparam logic [2:0]  IDX_STATUS     = 3'h2;
  localparam logic [2:0]  IDX_CONTROL    = 3'h3;
  localparam logic [2:0]  IDX_PERIOD     = 3'h4;
  localparam int          CTL_IRQ_EN_BIT = 0;
  localparam int          CTL_CLK_SRC_BIT = 6;
  localparam int          CTL_REARM_BIT  = 12;
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET   = 16'h0000;
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          UNIT_US        = 500;
  localparam int          UNIT_CYCLES    = CLK_HZ / 1_000_000 * UNIT_US;
  localparam int          CCLK_DIV       = 50;
  localparam int          CCLK_LOSS_CYC  = 256;
  localparam int          CCLK_LOSS_W    = 9;
  localparam logic [11:0] APB_CMD        = 12'h000;
  localparam logic [11:0] APB_WDATA      = 12'h004;
  localparam logic [11:0] APB_RDATA      = 12'h008;
  localparam logic [11:0] APB_STATUS     = 12'h00C;
  localparam logic [11:0] APB_IRQCNT     = 12'h010;
endpackage : rpr_pkg
